// ### hdl/free_divider.sv
`timescale 1ns/10ps
`default_nettype none
module free_divider
  import tick_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic step,
  output logic [W-1:0] count
);
  // a one-bit chain has no tap worth selecting
  if (W < 2) begin : g_width_check
    $error("free_divider width too small");
  end

  // gated only by step: the chain runs whatever the enable says
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (step) begin
      count <= count + W'(1);
    end
  end
endmodule : free_divider
`default_nettype wire

// ### hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### hdl/tick_pkg.sv
package tick_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] TICK_CTRL_ADDR = 8'h39;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h3a;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h3b;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h3c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int EN_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int CTRL_USED_W = 4;
  localparam int IRQ_TICK_BIT = 0;
  localparam int IRQ_RESERVED_BIT = 1;
  localparam int IRQ_W = 2;
  // rate codes the low clock cannot serve
  localparam logic [RATE_W-1:0] LOW_RESERVED_CODE = 3'h7;
  localparam logic [RATE_W-1:0] SLOW_FIRST_RESERVED = 3'h2;

  // ==========================================================================
  // divider geometry
  localparam int DIV_W = 23;
  localparam int GEAR_SPAN = 22;
  localparam int LOW_SPAN = 15;

  // ==========================================================================
  // chip operating modes
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_IDLE = 4'h2,
    MODE_SLOW = 4'h4,
    MODE_STOP = 4'h8
  } op_mode_t;

  typedef struct packed {
    logic enable;
    logic [RATE_W-1:0] rate;
  } tick_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // tap index per rate code; the two tables differ by clock source
  function automatic logic [4:0] gear_tap(input logic [RATE_W-1:0] code);
    logic [4:0] t;
    t = 5'h00;
    unique case (code)
      3'h0: t = 5'h15;
      3'h1: t = 5'h13;
      3'h2: t = 5'h0e;
      3'h3: t = 5'h0c;
      3'h4: t = 5'h0b;
      3'h5: t = 5'h0a;
      3'h6: t = 5'h09;
      3'h7: t = 5'h07;
    endcase
    return t;
  endfunction : gear_tap

  function automatic logic [4:0] low_tap(input logic [RATE_W-1:0] code);
    logic [4:0] t;
    t = 5'h00;
    unique case (code)
      3'h0: t = 5'h0e;
      3'h1: t = 5'h0c;
      3'h2: t = 5'h07;
      3'h3: t = 5'h05;
      3'h4: t = 5'h04;
      3'h5: t = 5'h03;
      3'h6: t = 5'h02;
      3'h7: t = 5'h00;
    endcase
    return t;
  endfunction : low_tap

endpackage : tick_pkg

// ### hdl/tick_timer.sv
// Overview of operation
// - while enabled, pulse a tick request at each falling edge of divided source.
// - while disabled, never issue a tick request.
// - gear clock rates for codes 0..7: 2^22,20,15,13,12,11,10,8.
// - low clock rates 2^15,13,8,6,5,4,3; code 7 reserved; slow limits.
// - entering stop clears the enable and keeps the rate field.
// - the divider chain runs regardless of the enable.
// - first tick at the next falling edge after enable; may be short.
// - control bits 7 to 4 read as zero.
// - low clock resynchronised to gear clock, so ticks may jitter.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module tick_timer
  import tick_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic gear_step,
  input wire logic low_freq_clock,
  input wire logic low_clock_prescale_select,
  input wire logic [3:0] op_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic tick_interrupt_request,
  output logic irq
);
  // ==========================================================================
  // elaboration checks on the shared constants
  // the struct overlay needs the enable just above the rate field
  if (EN_BIT != RATE_LSB + RATE_W) begin : g_en_bit_check
    $error("enable bit must sit just above the rate field");
  end
  if (CTRL_USED_W != RATE_W + 1) begin : g_ctrl_width_check
    $error("control width must be rate plus enable");
  end
  // a five-bit tap index cannot reach beyond bit 31
  if (DIV_W > 32 || DIV_W <= GEAR_SPAN || DIV_W <= LOW_SPAN) begin : g_div_width_check
    $error("divider width cannot serve the longest division");
  end
  if (IRQ_TICK_BIT >= IRQ_W || IRQ_RESERVED_BIT >= IRQ_W) begin : g_irq_width_check
    $error("interrupt bits do not fit the status width");
  end

  // one address compare shared by every write-side register
  function automatic logic write_hit(input reg_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : write_hit

  // ==========================================================================
  // request bundling and mode decode
  reg_req_t req;
  op_mode_t mode;
  logic slow_mode;
  logic use_low;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign mode = op_mode_t'(op_mode);
  assign slow_mode = (mode == MODE_SLOW);
  assign use_low = slow_mode || low_clock_prescale_select;

  // ==========================================================================
  // low clock resync and edge step
  // the low clock is foreign, so it is resynchronised; this is the jitter
  logic low_sync;
  logic low_prev_reg;
  logic low_step;

  pin_sync #(.W(1)) u_low_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(low_freq_clock),
    .sync_out(low_sync)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_prev_reg <= 1'b0;
    end else begin
      low_prev_reg <= low_sync;
    end
  end

  assign low_step = low_sync && !low_prev_reg;

  // ==========================================================================
  // free-running dividers
  logic [DIV_W-1:0] gear_count;
  logic [DIV_W-1:0] low_count;

  free_divider #(.W(DIV_W)) u_gear_div (
    .clk(clk),
    .rst_b(rst_b),
    .step(gear_step),
    .count(gear_count)
  );

  free_divider #(.W(DIV_W)) u_low_div (
    .clk(clk),
    .rst_b(rst_b),
    .step(low_step),
    .count(low_count)
  );

  // ==========================================================================
  // control register
  tick_ctrl_t ctrl_reg;
  logic stop_prev_reg;
  logic stop_entry;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_prev_reg <= 1'b0;
    end else begin
      stop_prev_reg <= (mode == MODE_STOP);
    end
  end

  assign stop_entry = (mode == MODE_STOP) && !stop_prev_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= tick_ctrl_t'(CTRL_RESET[CTRL_USED_W-1:0]);
    end else begin
      if (write_hit(req, TICK_CTRL_ADDR)) begin
        ctrl_reg.enable <= req.wdata[EN_BIT];
        ctrl_reg.rate <= req.wdata[RATE_LSB +: RATE_W];
      end
      if (stop_entry) begin
        ctrl_reg.enable <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // source selection
  logic [4:0] tap;
  logic src_level;
  logic src_prev_reg;
  logic reserved_code;

  assign tap = use_low ? low_tap(ctrl_reg.rate) : gear_tap(ctrl_reg.rate);
  assign src_level = use_low ? low_count[tap] : gear_count[tap];

  assign reserved_code = use_low &&
    ((ctrl_reg.rate == LOW_RESERVED_CODE) ||
     (slow_mode && ctrl_reg.rate >= SLOW_FIRST_RESERVED));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  // ==========================================================================
  // tick request
  logic tick_fire;

  // falling edge, next edge after enable, gated
  assign tick_fire = ctrl_reg.enable && !reserved_code && src_prev_reg && !src_level;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_interrupt_request <= 1'b0;
    end else begin
      tick_interrupt_request <= tick_fire;
    end
  end

  // ==========================================================================
  // interrupt status and enable
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  logic [IRQ_W-1:0] irq_status_next;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_TICK_BIT] = tick_fire;
  end

  assign irq_clr = write_hit(req, IRQ_CLEAR_ADDR) ? req.wdata[IRQ_W-1:0] : '0;
  // set wins over a clear in the same cycle, so no tick is ever lost
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_reg <= '0;
    end else if (write_hit(req, IRQ_ENABLE_ADDR)) begin
      irq_enable_reg <= req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ==========================================================================
  // read path
  logic [7:0] rd_next;

  always_comb begin
    rd_next = 8'h00;
    unique case (req.addr)
      TICK_CTRL_ADDR: rd_next = {4'h0, ctrl_reg};
      IRQ_STATUS_ADDR: rd_next = {6'h00, irq_status_reg};
      IRQ_ENABLE_ADDR: rd_next = {6'h00, irq_enable_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= rd_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : tick_timer
`default_nettype wire

// ### tb/clock_source.sv
`timescale 1ns/10ps
`default_nettype none
module clock_source (
  output logic gear_step,
  output logic low_freq_clock
);
  // ========
  // clock generator
  // gear at system rate keeps long divisions short
  assign gear_step = 1'b1;
  // free-running, phase kept off the system edges
  initial begin
    low_freq_clock = 1'b0;
    #1.3;
    forever #20 low_freq_clock = ~low_freq_clock;
  end
endmodule : clock_source
`default_nettype wire

// ### tb/tick_timer_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tick_timer_properties
  import tick_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] op_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tick_interrupt_request,
  input wire logic irq
);
  // ========
  // port checks
  wire logic tk = tick_interrupt_request;
  wire logic ctrl_rd = reg_rd && reg_addr == TICK_CTRL_ADDR;
  wire logic stop = op_mode == MODE_STOP;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  tick_spacing_a: assert property (tk |=> !tk[*8])
    else $error("tick too soon");
  irq_rise_a: assert property ($rose(irq) |-> tk || $past(reg_wr, 2))
    else $error("irq rose alone");
  irq_drop_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq fell alone");
  ctrl_upper_a: assert property ($past(ctrl_rd) |-> reg_rdata[7:4] == 4'h0)
    else $error("upper bits set");
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  stop_quiet_a: assert property (stop[*3] |-> !tk)
    else $error("tick in stop");
  stop_clear_a: assert property (
    ctrl_rd && stop && $past(stop) && !$past(reg_wr) |=> !reg_rdata[EN_BIT])
    else $error("enable kept in stop");
  off_quiet_a: assert property (
    reg_wr && reg_addr == TICK_CTRL_ADDR && !reg_wdata[EN_BIT] |-> ##2 !tk)
    else $error("tick while off");
  cover property (tk);
  cover property ($rose(irq));
  cover property (stop ##1 ctrl_rd);
endmodule : tick_timer_properties
bind tick_timer tick_timer_properties i_tick_timer_properties (.clk(clk), .rst_b(rst_b),
  .op_mode(op_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .tick_interrupt_request(tick_interrupt_request));
`default_nettype wire

// ### tb/tick_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module tick_timer_test
  import tick_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] mode = 4'h1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] d, rdata;
  logic gear_step, low_freq_clock, tick, irq;
  int fails = 0;
  int n_tests = 0;
  int n;
  // ========
  // harness
  always #2.5 clk = ~clk;
  clock_source i_clock_source (.gear_step(gear_step), .low_freq_clock(low_freq_clock));
  tick_timer i_tick_timer (.clk(clk), .rst_b(rst_b), .gear_step(gear_step),
    .low_freq_clock(low_freq_clock), .low_clock_prescale_select(sel), .op_mode(mode),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .tick_interrupt_request(tick), .irq(irq));
  task summarize;
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // a lost tick ends the run, later steps would only cascade
  task wait_tick;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 600);
    if (tick !== 1'b1) begin
      fails++;
      summarize;
    end
  endtask : wait_tick
  task quiet(input int cyc);
    repeat (2) @(negedge clk);
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (tick !== 1'b0) n++;
    end
  endtask : quiet
  // ========
  // scenarios
  task t_reset;
    rd_reg(TICK_CTRL_ADDR);
    check(16'(d), 16'(CTRL_RESET));
    rd_reg(8'h40);
    check(16'(d), 16'h0000);
  endtask : t_reset
  task t_gear;
    wr_reg(TICK_CTRL_ADDR, 8'h07);
    wr_reg(TICK_CTRL_ADDR, 8'h0f);
    wait_tick;
    check(16'(n <= 256), 16'h0001);
    wait_tick;
    check(n[15:0], 16'h0100);
    wr_reg(TICK_CTRL_ADDR, 8'hf7);
    rd_reg(TICK_CTRL_ADDR);
    check(16'(d), 16'h0007);
    quiet(600);
    check(n[15:0], 16'h0000);
  endtask : t_gear
  task t_low;
    @(posedge clk);
    sel <= 1'b1;
    wr_reg(TICK_CTRL_ADDR, 8'h06);
    wr_reg(TICK_CTRL_ADDR, 8'h0e);
    wait_tick;
    wait_tick;
    check(n[15:0], 16'h0040);
    wr_reg(TICK_CTRL_ADDR, 8'h07);
    wr_reg(TICK_CTRL_ADDR, 8'h0f);
    quiet(300);
    check(n[15:0], 16'h0000);
    wr_reg(TICK_CTRL_ADDR, 8'h06);
    mode <= 4'h4;
    wr_reg(TICK_CTRL_ADDR, 8'h0e);
    quiet(300);
    check(n[15:0], 16'h0000);
    wr_reg(TICK_CTRL_ADDR, 8'h06);
    mode <= 4'h1;
    sel <= 1'b0;
  endtask : t_low
  task t_irq;
    wr_reg(TICK_CTRL_ADDR, 8'h07);
    // earlier scenarios left the tick status set; start from a clean slate
    wr_reg(IRQ_CLEAR_ADDR, 8'h01);
    wr_reg(IRQ_ENABLE_ADDR, 8'h01);
    rd_reg(IRQ_STATUS_ADDR);
    check(16'(d), 16'h0000);
    check(16'(irq), 16'h0000);
    wr_reg(TICK_CTRL_ADDR, 8'h0f);
    wait_tick;
    @(negedge clk);
    check(16'(irq), 16'h0001);
    wr_reg(TICK_CTRL_ADDR, 8'h07);
    rd_reg(IRQ_STATUS_ADDR);
    check(16'(d), 16'h0001);
    wr_reg(IRQ_ENABLE_ADDR, 8'h00);
    rd_reg(8'h40);
    check(16'(irq), 16'h0000);
    wr_reg(IRQ_ENABLE_ADDR, 8'h01);
    rd_reg(8'h40);
    check(16'(irq), 16'h0001);
    wr_reg(IRQ_CLEAR_ADDR, 8'h01);
    rd_reg(IRQ_STATUS_ADDR);
    check(16'(d), 16'h0000);
    check(16'(irq), 16'h0000);
  endtask : t_irq
  task t_stop;
    wr_reg(TICK_CTRL_ADDR, 8'h0f);
    mode <= 4'h8;
    repeat (3) @(posedge clk);
    rd_reg(TICK_CTRL_ADDR);
    check(16'(d), 16'h0007);
    quiet(300);
    check(n[15:0], 16'h0000);
  endtask : t_stop
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_gear;
    t_low;
    t_irq;
    t_stop;
    summarize;
  end
endmodule : tick_timer_test
`default_nettype wire
